/* File: pmr_consts.svh */
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH

// ==========================================================
// Register indices; the byte address is four times the index
`define PMR_IDX_SYS_MON     8'h00
`define PMR_IDX_SYS_MST     8'h01
`define PMR_IDX_B1_PRI      8'h20
`define PMR_IDX_B1_SEC      8'h21
`define PMR_IDX_B1_CTL      8'h22
`define PMR_IDX_B2_PRI      8'h30
`define PMR_IDX_B2_SEC      8'h31
`define PMR_IDX_B2_CTL      8'h32
`define PMR_IDX_B3_PRI      8'h40
`define PMR_IDX_B3_SEC      8'h41
`define PMR_IDX_B3_CTL      8'h42
`define PMR_IDX_IRQ_STAT    8'h80
`define PMR_IDX_IRQ_CLR     8'h81
`define PMR_IDX_IRQ_EN      8'h82

// ==========================================================
// Field positions
`define PMR_TRST_BIT        7
`define PMR_MODE_SEL_BIT    6
`define PMR_UNMASK_BIT      5
`define PMR_LOWSTAT_BIT     4
`define PMR_MSTOFF_BIT      5
`define PMR_ON_BIT          7
`define PMR_PHASE_BIT       6
`define PMR_PWM_BIT         5
`define PMR_FLTEN_BIT       1
`define PMR_OK_BIT          0

// ==========================================================
// Reset values of writable bytes
`define PMR_RST_SYS_MON     8'h00
`define PMR_RST_SYS_MST     8'h00
`define PMR_RST_VCODE       6'h00
`define PMR_RST_CTL         8'h00

// ==========================================================
// Timing
`define PMR_CLK_HZ          40000000
`define PMR_TOUT_SHORT_MS   64
`define PMR_TOUT_LONG_MS    260

`endif

/* File: pmr_pkg.sv */
package pmr_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic       write;
        logic       read;
    } pmr_req_t;

    typedef struct packed {
        logic       on;
        logic       phase;
        logic       pwm;
        logic [2:0] delay;
        logic       flt_en;
    } pmr_ctl_t;

    typedef enum logic [1:0] {
        PMR_RST_HOLD = 2'b00,
        PMR_RST_RUN  = 2'b01,
        PMR_RST_DONE = 2'b11
    } pmr_rst_state_t;
endpackage : pmr_pkg

/* File: pmr_vcode_mem.sv */
`include "pmr_consts.svh"
// Six voltage codes, registered read port
module pmr_vcode_mem #(
    parameter int DEPTH = 6
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       clr,
    // Write port
    input  wire logic       we,
    input  wire logic [2:0] waddr,
    input  wire logic [5:0] wdata,
    // Read port
    input  wire logic [2:0] raddr,
    output logic [5:0]      rdata,
    // All words for the output selection
    output logic [DEPTH*6-1:0] all_words
);
    logic [5:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (!nrst || clr) begin
            for (int i = 0; i < DEPTH; i++) mem[i] <= `PMR_RST_VCODE;
        end else if (we && waddr < 3'(DEPTH)) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdata <= `PMR_RST_VCODE;
        end else begin
            rdata <= (raddr < 3'(DEPTH)) ? mem[raddr] : 6'h00;
        end
    end

    always_comb begin
        for (int i = 0; i < DEPTH; i++) all_words[i*6 +: 6] = mem[i];
    end
endmodule : pmr_vcode_mem

/* File: pmr_reset_timer.sv */
`include "pmr_consts.svh"
// Reset time-out counter with the selectable length
module pmr_reset_timer #(
    parameter int SHORT_CYC = `PMR_CLK_HZ / 1000 * `PMR_TOUT_SHORT_MS,
    parameter int LONG_CYC  = `PMR_CLK_HZ / 1000 * `PMR_TOUT_LONG_MS
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // Control
    input  wire logic start,
    input  wire logic short_sel,
    // Status
    output logic      busy,
    output logic      done
);
    pmr_pkg::pmr_rst_state_t state;
    logic [31:0]             cnt;
    wire  [31:0]             limit = short_sel ? 32'(SHORT_CYC) : 32'(LONG_CYC);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state <= pmr_pkg::PMR_RST_HOLD;
            cnt   <= 32'h0000_0000;
        end else begin
            case (state)
                pmr_pkg::PMR_RST_HOLD: begin
                    cnt <= 32'h0000_0000;
                    if (start) state <= pmr_pkg::PMR_RST_RUN;
                end
                pmr_pkg::PMR_RST_RUN: begin
                    cnt <= cnt + 32'h0000_0001;
                    if (cnt + 32'h0000_0001 >= limit) state <= pmr_pkg::PMR_RST_DONE;
                end
                pmr_pkg::PMR_RST_DONE: begin
                    if (start) state <= pmr_pkg::PMR_RST_HOLD;
                end
                default: state <= pmr_pkg::PMR_RST_HOLD;
            endcase
        end
    end

    assign busy = (state == pmr_pkg::PMR_RST_RUN);
    assign done = (state == pmr_pkg::PMR_RST_DONE);
endmodule : pmr_reset_timer

/* File: pmr_regs.sv */
//
// Behaviour
// - Reset time-out 64ms if select 1, else 260ms
// - Monitor mode 1 interrupts, 0 shuts down
// - Monitor interrupt masked until unmask bit set
// - Supply-low status reads live comparator state
// - Four-bit monitor threshold field, read/write
// - Master-off kills regulators; push-button clears it
// - Spare_storage_bits bits read/write, cleared at UVLO
// - Primary code drives output when select low
// - Secondary code drives output when select high
// - Enable bit turns regulator on or off
// - Phase bit on bucks one, two; reserved three
// - Mode bit forces PWM, else power saving
// - Three-bit turn-on delay field per regulator
// - Fault enable bit gates fault interrupt
// - Power-good bit reads live output state
// - All bits return to defaults at UVLO
//
// Register access over AHB-Lite was chosen for this implementation.
`include "pmr_consts.svh"
module pmr_regs #(
    parameter int SHORT_CYC = `PMR_CLK_HZ / 1000 * `PMR_TOUT_SHORT_MS,
    parameter int LONG_CYC  = `PMR_CLK_HZ / 1000 * `PMR_TOUT_LONG_MS
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Analog status inputs
    input  wire logic        uvlo,
    input  wire logic        supply_below,
    input  wire logic [2:0]  power_good,
    input  wire logic [2:0]  reg_fault,
    input  wire logic        push_button_input_n,
    input  wire logic        voltage_set_pin,
    // Regulator controls
    output logic [2:0]       reg_on,
    output logic [1:0]       reg_phase,
    output logic [2:0]       reg_pwm,
    output logic [8:0]       reg_delay,
    output logic [17:0]      reg_vcode,
    output logic [3:0]       supply_monitor_threshold,
    output logic             auto_shutdown,
    output logic             reset_output_n,
    output logic             irq
);
    // ==========================================================
    // Bus address phase capture
    pmr_pkg::pmr_req_t req;
    wire  take   = hsel && hready && htrans[1];
    // Byte offset is the register index, as a word address
    wire  [7:0] idx_a = haddr[9:2];
    wire  rst_all = !nrst || uvlo;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst_all);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            req <= '0;
        end else begin
            req.addr  <= take ? idx_a : 8'h00;
            req.write <= take && hwrite;
            req.read  <= take && !hwrite;
        end
    end

    wire [7:0] wd = hwdata[7:0];
    function automatic logic wr_hit(input pmr_pkg::pmr_req_t r, input logic [7:0] a);
        return r.write && (r.addr == a);
    endfunction : wr_hit

    // ==========================================================
    // System bytes
    logic        trst;
    logic        mode_sel;
    logic        monitor_irq_unmask;
    logic [1:0]  mst_rsv_hi;
    logic        all_regulators_off;
    logic        mst_rsv;
    logic [3:0]  spare_storage_bits;
    logic [3:0]  thr;

    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            {trst, mode_sel, monitor_irq_unmask} <= 3'h0;
            thr                <= 4'h0;
            mst_rsv_hi         <= 2'h0;
            mst_rsv            <= 1'b0;
            spare_storage_bits <= 4'h0;
        end else begin
            if (wr_hit(req, `PMR_IDX_SYS_MON)) begin
                trst               <= wd[`PMR_TRST_BIT];
                mode_sel           <= wd[`PMR_MODE_SEL_BIT];
                monitor_irq_unmask <= wd[`PMR_UNMASK_BIT];
                thr                <= wd[3:0];
            end
            if (wr_hit(req, `PMR_IDX_SYS_MST)) begin
                mst_rsv_hi         <= wd[7:6];
                mst_rsv            <= wd[4];
                spare_storage_bits <= wd[3:0];
            end
        end
    end

    // Push-button wins over a same-cycle write so the release is never lost
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            all_regulators_off <= 1'b0;
        end else if (!push_button_input_n) begin
            all_regulators_off <= 1'b0;
        end else if (wr_hit(req, `PMR_IDX_SYS_MST)) begin
            all_regulators_off <= wd[`PMR_MSTOFF_BIT];
        end
    end

    spare_storage_bits_uvlo_a: assert property (disable iff (!nrst)
        uvlo |=> spare_storage_bits == 4'h0 && thr == 4'h0)
        else $error("system bits kept through uvlo");

    // ==========================================================
    // Regulator control bytes
    pmr_pkg::pmr_ctl_t ctl [3];
    wire [7:0] ctl_idx [3] = '{`PMR_IDX_B1_CTL, `PMR_IDX_B2_CTL, `PMR_IDX_B3_CTL};

    for (genvar g = 0; g < 3; g++) begin : g_ctl
        always_ff @(posedge core_clk) begin
            if (rst_all) begin
                ctl[g] <= pmr_pkg::pmr_ctl_t'(7'(`PMR_RST_CTL >> 1));
            end else if (wr_hit(req, ctl_idx[g])) begin
                ctl[g].on     <= wd[`PMR_ON_BIT];
                ctl[g].phase  <= (g < 2) ? wd[`PMR_PHASE_BIT] : 1'b0;
                ctl[g].pwm    <= wd[`PMR_PWM_BIT];
                ctl[g].delay  <= wd[4:2];
                ctl[g].flt_en <= wd[`PMR_FLTEN_BIT];
            end
        end
    end

    ctl_uvlo_a: assert property (disable iff (!nrst)
        uvlo |=> ctl[0] == '0 && ctl[1] == '0 && ctl[2] == '0)
        else $error("control bytes kept through uvlo");

    // ==========================================================
    // Voltage code memory: word 2k primary, 2k+1 secondary
    function automatic logic [2:0] code_slot(input logic [7:0] a);
        case (a)
            `PMR_IDX_B1_PRI: code_slot = 3'h0;
            `PMR_IDX_B1_SEC: code_slot = 3'h1;
            `PMR_IDX_B2_PRI: code_slot = 3'h2;
            `PMR_IDX_B2_SEC: code_slot = 3'h3;
            `PMR_IDX_B3_PRI: code_slot = 3'h4;
            `PMR_IDX_B3_SEC: code_slot = 3'h5;
            default:         code_slot = 3'h7;
        endcase
    endfunction : code_slot

    wire [2:0]  w_slot = code_slot(req.addr);
    wire [2:0]  r_slot = code_slot(idx_a);
    wire [5:0]  code_rd;
    wire [35:0] codes;

    pmr_vcode_mem #(.DEPTH(6)) u_mem (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .clr       (uvlo),
        .we        (req.write && w_slot != 3'h7),
        .waddr     (w_slot),
        .wdata     (wd[5:0]),
        .raddr     (r_slot),
        .rdata     (code_rd),
        .all_words (codes)
    );

    codes_uvlo_a: assert property (disable iff (!nrst)
        uvlo |=> codes == 36'h0)
        else $error("voltage codes kept through uvlo");

    // ==========================================================
    // Interrupt status: bit0 monitor, bits 3:1 faults
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    wire  [2:0] flt_gate = {ctl[2].flt_en, ctl[1].flt_en, ctl[0].flt_en};
    wire  [3:0] irq_evt  = {reg_fault & flt_gate,
                            supply_below && mode_sel && monitor_irq_unmask};
    wire  [3:0] irq_clr  = wr_hit(req, `PMR_IDX_IRQ_CLR) ? wd[3:0] : 4'h0;

    // Set beats clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            irq_stat <= 4'h0;
            irq_en   <= 4'h0;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
            if (wr_hit(req, `PMR_IDX_IRQ_EN)) irq_en <= wd[3:0];
        end
    end

    monitor_set_a: assert property (
        supply_below && mode_sel && monitor_irq_unmask |=> irq_stat[0])
        else $error("monitor event lost");

    fault_set_a: assert property (
        reg_fault[0] && ctl[0].flt_en |=> irq_stat[1])
        else $error("enabled fault lost");

    fault_gated_a: assert property (
        !ctl[1].flt_en && !irq_stat[2] |=> !irq_stat[2])
        else $error("disabled fault latched");

    // ==========================================================
    // Reset output timer
    logic tmr_busy;
    logic tmr_done;
    pmr_reset_timer #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_tmr (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .start     (!tmr_busy && !tmr_done && !uvlo),
        .short_sel (trst),
        .busy      (tmr_busy),
        .done      (tmr_done)
    );

    resetout_hold_a: assert property (
        !tmr_done |=> !reset_output_n)
        else $error("reset output released early");

    // ==========================================================
    // Read mux
    wire [7:0] sys_mon_rd = {trst, mode_sel, monitor_irq_unmask, supply_below, thr};
    wire [7:0] sys_mst_rd = {mst_rsv_hi, all_regulators_off, mst_rsv, spare_storage_bits};

    function automatic logic [7:0] ctl_rd(input pmr_pkg::pmr_ctl_t c, input logic ok);
        return {c.on, c.phase, c.pwm, c.delay, c.flt_en, ok};
    endfunction : ctl_rd

    logic [7:0] rd_byte;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rd_byte <= 8'h00;
        end else if (take && !hwrite) begin
            case (idx_a)
                `PMR_IDX_SYS_MON:  rd_byte <= sys_mon_rd;
                `PMR_IDX_SYS_MST:  rd_byte <= sys_mst_rd;
                `PMR_IDX_B1_CTL:   rd_byte <= ctl_rd(ctl[0], power_good[0]);
                `PMR_IDX_B2_CTL:   rd_byte <= ctl_rd(ctl[1], power_good[1]);
                `PMR_IDX_B3_CTL:   rd_byte <= ctl_rd(ctl[2], power_good[2]);
                `PMR_IDX_IRQ_STAT: rd_byte <= {4'h0, irq_stat};
                `PMR_IDX_IRQ_EN:   rd_byte <= {4'h0, irq_en};
                default:           rd_byte <= 8'h00;
            endcase
        end
    end

    logic rd_code;
    always_ff @(posedge core_clk) begin
        if (!nrst) rd_code <= 1'b0;
        else       rd_code <= take && !hwrite && r_slot != 3'h7;
    end

    // Code reads come from the memory register, upper bits zero
    assign hrdata    = rd_code ? {26'h0, code_rd} : {24'h0, rd_byte};
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ==========================================================
    // Outputs, all registered
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            reg_on                   <= 3'h0;
            reg_phase                <= 2'h0;
            reg_pwm                  <= 3'h0;
            reg_delay                <= 9'h000;
            reg_vcode                <= 18'h00000;
            supply_monitor_threshold <= 4'h0;
            auto_shutdown            <= 1'b0;
            reset_output_n           <= 1'b0;
            irq                      <= 1'b0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                reg_on[i]          <= ctl[i].on && !all_regulators_off;
                reg_pwm[i]         <= ctl[i].pwm;
                reg_delay[i*3 +: 3] <= ctl[i].delay;
                reg_vcode[i*6 +: 6] <= voltage_set_pin ? codes[(2*i+1)*6 +: 6]
                                                       : codes[(2*i)*6 +: 6];
            end
            reg_phase                <= {ctl[1].phase, ctl[0].phase};
            supply_monitor_threshold <= thr;
            auto_shutdown            <= supply_below && !mode_sel;
            reset_output_n           <= tmr_done;
            irq                      <= |(irq_stat & irq_en);
        end
    end

    on_follow_a: assert property (
        !all_regulators_off |=> reg_on == $past({ctl[2].on, ctl[1].on, ctl[0].on}))
        else $error("enable bits not applied");

    pwm_follow_a: assert property (
        1'b1 |=> reg_pwm == $past({ctl[2].pwm, ctl[1].pwm, ctl[0].pwm}))
        else $error("mode bits not applied");

    delay_follow_a: assert property (
        1'b1 |=> reg_delay == $past({ctl[2].delay, ctl[1].delay, ctl[0].delay}))
        else $error("delay fields not applied");

    voltage_set_pin_low_a: assert property (
        !voltage_set_pin |=> reg_vcode[17:12] == $past(codes[29:24]))
        else $error("primary code not used");

    thr_follow_a: assert property (
        1'b1 |=> supply_monitor_threshold == $past(thr))
        else $error("threshold not applied");

    no_shutdown_a: assert property (
        mode_sel |=> !auto_shutdown)
        else $error("shutdown in interrupt mode");

    // ==========================================================
    // Checks
    pushbtn_clears_a: assert property (
        !push_button_input_n |=> !all_regulators_off) else $error("master off not cleared");
    masteroff_kills_a: assert property (
        all_regulators_off |=> reg_on == 3'h0) else $error("regulator on under master off");
    monitor_masked_a: assert property (
        !monitor_irq_unmask && !irq_stat[0] |=> !irq_stat[0])
        else $error("masked monitor event");
    shutdown_mode_a: assert property (
        (supply_below && !mode_sel) |=> auto_shutdown) else $error("no auto shutdown");
    status_live_a: assert property (disable iff (!nrst)
        (take && !hwrite && idx_a == `PMR_IDX_SYS_MON)
        |=> hrdata[`PMR_LOWSTAT_BIT] == $past(supply_below)) else $error("status stale");
    voltage_set_pin_pick_a: assert property (
        ##1 voltage_set_pin && $stable(codes) |=> reg_vcode[5:0] == $past(codes[11:6]))
        else $error("secondary code not used");
    phase3_zero_a: assert property (disable iff (!nrst)
        ctl[2].phase == 1'b0) else $error("reserved phase bit set");
    irq_or_a: assert property (
        (|(irq_stat & irq_en)) |=> irq) else $error("irq not raised");
    code_resv_a: assert property (disable iff (!nrst)
        take && !hwrite && r_slot != 3'h7
        |=> hrdata == {26'h0, $past(codes[r_slot*6 +: 6])}) else $error("code read wrong");
endmodule : pmr_regs

/* File: pmr_host_model.sv */
// ==========================================================
// Host side: single-word AHB-Lite master
module pmr_host_model (
    // Clock
    input  wire logic        core_clk,
    // AHB-Lite master outputs
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    // Slave answer
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0000_0000;
    end

    // Waits are unbounded here; the bench timeout cuts a hang
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {22'h000000, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        // Stale write data is inverted so nothing leans on it
        hwdata <= ~hwdata;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge core_clk);
        while (hready !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask : xfer
endmodule : pmr_host_model

/* File: tb_pmr_regs.sv */
`include "pmr_consts.svh"
module tb_pmr_regs;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Signals
    logic        core_clk, nrst, uvlo, supply_below, push_button_input_n, voltage_set_pin;
    logic [2:0]  power_good, reg_fault, reg_on, reg_pwm;
    logic        hsel, hwrite, hreadyout, hresp, auto_shutdown, reset_output_n, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans, reg_phase;
    logic [2:0]  hsize;
    logic [8:0]  reg_delay;
    logic [17:0] reg_vcode;
    logic [3:0]  supply_monitor_threshold;
    int          error_cnt, n_compared, cyc, cnt;

    localparam logic [7:0] RIDX [11] = '{`PMR_IDX_SYS_MON, `PMR_IDX_SYS_MST, `PMR_IDX_B1_PRI,
        `PMR_IDX_B1_SEC, `PMR_IDX_B1_CTL, `PMR_IDX_B2_PRI, `PMR_IDX_B2_SEC, `PMR_IDX_B2_CTL,
        `PMR_IDX_B3_PRI, `PMR_IDX_B3_SEC, `PMR_IDX_B3_CTL};
    localparam logic [7:0] WVAL [11] = '{8'h6B, 8'h0F, 8'hFF, 8'h2A, 8'hFF, 8'h15, 8'hC7,
        8'h08, 8'h3C, 8'h01, 8'hA5};
    // Status bits read 0 here: supply high, no power-good
    localparam logic [7:0] REXP [11] = '{8'h6B, 8'h0F, 8'h3F, 8'h2A, 8'hFE, 8'h15, 8'h07,
        8'h08, 8'h3C, 8'h01, 8'hA4};

    // ==========================================================
    // Design and host
    pmr_regs #(.SHORT_CYC(16), .LONG_CYC(64)) u_pmr_regs (
        .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .uvlo(uvlo),
        .supply_below(supply_below), .power_good(power_good), .reg_fault(reg_fault),
        .push_button_input_n(push_button_input_n), .voltage_set_pin(voltage_set_pin),
        .reg_on(reg_on), .reg_phase(reg_phase), .reg_pwm(reg_pwm), .reg_delay(reg_delay),
        .reg_vcode(reg_vcode), .supply_monitor_threshold(supply_monitor_threshold),
        .auto_shutdown(auto_shutdown), .reset_output_n(reset_output_n), .irq(irq));

    pmr_host_model u_pmr_host_model (
        .core_clk(core_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    // ==========================================================
    // Clock and timeout
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            end_of_test();
        end
    end

    // ==========================================================
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        u_pmr_host_model.xfer(1'b1, idx, {24'h000000, d}, r);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] e);
        logic [31:0] r;
        u_pmr_host_model.xfer(1'b0, idx, 32'h0000_0000, r);
        chk(nm, {24'h000000, e}, {24'h000000, r[7:0]});
    endtask : rd_chk

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // ==========================================================
    // Tests
    initial begin
        nrst = 1'b0; uvlo = 1'b0; supply_below = 1'b0; push_button_input_n = 1'b1;
        voltage_set_pin = 1'b0; power_good = 3'h0; reg_fault = 3'h0;
        error_cnt = 0; n_compared = 0; cyc = 0; cnt = 0;
        tick(5);
        nrst <= 1'b1;
        while (reset_output_n !== 1'b1 && cnt < 200) begin
            tick(1);
            cnt++;
        end
        chk("reset_timeout", 32'h1, 32'(cnt >= 64 && cnt <= 67));
        $display("test reset_timer done");

        for (int i = 0; i < 11; i++) rd_chk("reset_value", RIDX[i], 8'h00);
        rd_chk("irq_status_reset", `PMR_IDX_IRQ_STAT, 8'h00);
        for (int i = 0; i < 11; i++) wr(RIDX[i], WVAL[i]);
        wr(8'h10, 8'hFF);
        for (int i = 0; i < 11; i++) rd_chk("readback", RIDX[i], REXP[i]);
        rd_chk("unmapped", 8'h10, 8'h00);
        tick(2);
        chk("vcode_primary", 32'({6'h3C, 6'h15, 6'h3F}), 32'(reg_vcode));
        chk("reg_on", 32'h5, 32'(reg_on));
        chk("reg_phase", 32'h1, 32'(reg_phase));
        chk("reg_pwm", 32'h5, 32'(reg_pwm));
        chk("reg_delay", 32'({3'h1, 3'h2, 3'h7}), 32'(reg_delay));
        chk("threshold", 32'hB, 32'(supply_monitor_threshold));
        chk("hresp", 32'h0, 32'(hresp));
        voltage_set_pin <= 1'b1;
        tick(3);
        chk("vcode_secondary", 32'({6'h01, 6'h07, 6'h2A}), 32'(reg_vcode));
        $display("test fields done");

        wr(`PMR_IDX_SYS_MST, 8'h2F);
        tick(2);
        chk("master_off", 32'h0, 32'(reg_on));
        push_button_input_n <= 1'b0;
        tick(3);
        push_button_input_n <= 1'b1;
        rd_chk("master_off_cleared", `PMR_IDX_SYS_MST, 8'h0F);
        tick(2);
        chk("reg_on_restored", 32'h5, 32'(reg_on));
        $display("test master_off done");

        supply_below <= 1'b1;
        power_good <= 3'h5;
        reg_fault <= 3'h3;
        tick(3);
        rd_chk("supply_low", `PMR_IDX_SYS_MON, 8'h7B);
        rd_chk("ok_b1", `PMR_IDX_B1_CTL, 8'hFF);
        rd_chk("ok_b2", `PMR_IDX_B2_CTL, 8'h08);
        rd_chk("ok_b3", `PMR_IDX_B3_CTL, 8'hA5);
        rd_chk("irq_status", `PMR_IDX_IRQ_STAT, 8'h03);
        chk("irq_disabled", 32'h0, 32'(irq));
        wr(`PMR_IDX_IRQ_EN, 8'h02);
        tick(2);
        chk("irq_fault", 32'h1, 32'(irq));
        supply_below <= 1'b0;
        reg_fault <= 3'h0;
        tick(2);
        wr(`PMR_IDX_IRQ_CLR, 8'h03);
        tick(2);
        rd_chk("irq_cleared", `PMR_IDX_IRQ_STAT, 8'h00);
        chk("irq_low", 32'h0, 32'(irq));
        wr(`PMR_IDX_IRQ_EN, 8'h01);
        wr(`PMR_IDX_SYS_MON, 8'h4B);
        supply_below <= 1'b1;
        tick(3);
        rd_chk("monitor_masked", `PMR_IDX_IRQ_STAT, 8'h00);
        chk("irq_masked", 32'h0, 32'(irq));
        chk("no_shutdown", 32'h0, 32'(auto_shutdown));
        wr(`PMR_IDX_SYS_MON, 8'h0B);
        tick(3);
        chk("auto_shutdown", 32'h1, 32'(auto_shutdown));
        rd_chk("no_monitor_irq", `PMR_IDX_IRQ_STAT, 8'h00);
        supply_below <= 1'b0;
        $display("test interrupts done");

        uvlo <= 1'b1;
        tick(2);
        uvlo <= 1'b0;
        tick(1);
        rd_chk("uvlo_spare_storage_bits", `PMR_IDX_SYS_MST, 8'h00);
        rd_chk("uvlo_code", `PMR_IDX_B1_PRI, 8'h00);
        tick(2);
        chk("uvlo_reg_on", 32'h0, 32'(reg_on));
        $display("test uvlo done");

        // Mid-run reset, then the short time-out picked while counting
        nrst <= 1'b0;
        tick(2);
        chk("reset_out_low", 32'h0, 32'(reset_output_n));
        nrst <= 1'b1;
        tick(1);
        wr(`PMR_IDX_SYS_MON, 8'h80);
        cnt = 0;
        while (reset_output_n !== 1'b1 && cnt < 200) begin
            tick(1);
            cnt++;
        end
        chk("short_timeout", 32'h1, 32'(cnt >= 14 && cnt <= 17));
        rd_chk("trst_readback", `PMR_IDX_SYS_MON, 8'h80);
        $display("test short_timer done");
        end_of_test();
    end
endmodule : tb_pmr_regs
